/* File: hw/lma_defs.svh */
// register offsets, field positions and reset values of the lin master assist control block
`ifndef LMA_DEFS_SVH
`define LMA_DEFS_SVH
`define LMA_ADDR_W 8
`define LMA_OFS_FEATURE 8'h80
`define LMA_OFS_ENABLE 8'h84
`define LMA_OFS_STATUS 8'ha0
`define LMA_OFS_IRQ_EN 8'ha4
`define LMA_OFS_TX_REQ 8'hd8
`define LMA_BIT_RX_MASK 0
`define LMA_BIT_TX_MASK 1
`define LMA_BIT_AUTO_FRAME 2
`define LMA_BIT_SCHED 3
`define LMA_BIT_CKS_AUTO 4
`define LMA_BIT_MODE_LO 5
`define LMA_BIT_MODE_HI 6
`define LMA_BIT_UNIT_EN 15
`define LMA_BIT_TX_REQ 0
`define LMA_STS_TX_DONE 0
`define LMA_STS_RX_DONE 1
`define LMA_STS_CKS_ERR 2
`define LMA_STS_HDR_ERR 3
`define LMA_STS_W 4
`define LMA_FEATURE_W 7
`define LMA_FEATURE_RST 7'h00
`define LMA_STS_RST 4'h0
`endif

/* File: hw/lma_pkg.sv */
// types shared by the lin master assist control block
package lma_pkg;
  typedef enum logic [1:0] {
    LMA_MD_THROUGH,
    LMA_MD_BUFFER,
    LMA_MD_LIN_CONT,
    LMA_MD_LIN_STOP
  } lma_mode_e;
  typedef enum logic [1:0] {
    LMA_FS_IDLE,
    LMA_FS_WAIT_IFS,
    LMA_FS_SEND,
    LMA_FS_CKS
  } lma_frame_e;
endpackage : lma_pkg

/* File: hw/lma_cks.sv */
// running lin checksum: 8-bit sum with end-around carry
`timescale 1ns/1ps
module lma_cks (
  input wire logic clk_i,        // clock
  input wire logic reset_i,      // async reset, active high
  input wire logic clear_i,      // restart the sum
  input wire logic add_i,        // accumulate byte_i
  input wire logic [7:0] byte_i, // data byte
  output logic [7:0] sum_o       // running sum, not inverted
);
  logic [7:0] sum_q;
  logic [8:0] acc;
  assign acc = {1'b0, sum_q} + {1'b0, byte_i};
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sum_q <= 8'h00;
    end else if (clear_i) begin
      sum_q <= 8'h00;
    end else if (add_i) begin
      // the carry folded back in can never overflow again
      sum_q <= acc[7:0] + {7'h00, acc[8]};
    end
  end
  assign sum_o = sum_q;
endmodule : lma_cks

/* File: hw/lma_ctrl.sv */
// control register bank and frame start logic of the lin master assist unit
//
// Functional notes
// - feature bit 4 enables automatic checksum
// - auto checksum compares received checksum byte
// - auto checksum appended when transmission runs
// - feature bit 3 enables frame scheduler
// - feature bit 2 enables automatic frame start
// - manual start launches frame on request
// - auto start launches right after interframe space
// - feature bit 1 masks tx done interrupt
// - feature bit 0 masks rx done interrupt
// - enable bit 15 runs unit clock
// - clearing enable halts and resets unit
// - mode select picks uart or lin variant
// - unimplemented bits ignore writes, read zero
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "lma_defs.svh"
module lma_ctrl (
  input wire logic clk_i,                      // clock, 100 MHz
  input wire logic reset_i,                    // async reset, active high
  input wire logic [`LMA_ADDR_W-1:0] addr_i,   // register byte address
  input wire logic [15:0] wdata_i,             // write data
  input wire logic wr_i,                       // write strobe
  input wire logic rd_i,                       // read strobe
  output logic [15:0] rdata_o,                 // read data, cycle after rd_i
  input wire logic ifs_elapsed_i,              // interframe space over, pulse
  input wire logic tx_byte_valid_i,            // frame byte handed to uart
  input wire logic [7:0] tx_byte_i,            // that byte
  input wire logic tx_byte_last_i,             // last data byte of frame
  input wire logic rx_byte_valid_i,            // byte received by uart
  input wire logic [7:0] rx_byte_i,            // that byte
  input wire logic rx_byte_last_i,             // byte is the checksum
  input wire logic hdr_err_i,                  // header consistency error
  output logic unit_clk_en_o,                  // internal clock enable
  output logic [1:0] mode_select_o,            // operation mode
  output logic scheduler_en_o,                 // scheduler running
  output logic checksum_auto_en_o,             // auto checksum feature bit, not gated by mode or enable
  output logic frame_start_o,                  // frame launched, pulse
  output logic tx_cks_valid_o,                 // inserted checksum, pulse
  output logic [7:0] tx_cks_o,                 // inserted checksum byte
  output logic tx_done_irq_o,                  // transmission done, pulse
  output logic rx_done_irq_o,                  // reception done, pulse
  output logic irq_o                           // combined level interrupt
);
  logic [`LMA_FEATURE_W-1:0] feat_q;
  logic en_q;
  logic sched_q;
  logic tx_req_q;
  logic [`LMA_STS_W-1:0] sts_q;
  logic [`LMA_STS_W-1:0] sts_d;
  logic [`LMA_STS_W-1:0] sts_set;
  logic [`LMA_STS_W-1:0] sts_clr;
  logic [`LMA_STS_W-1:0] irq_en_q;
  lma_pkg::lma_frame_e st_q;
  lma_pkg::lma_frame_e st_d;
  lma_pkg::lma_mode_e mode;
  logic [15:0] rdata_q;
  logic frame_start_q;
  logic tx_cks_valid_q;
  logic [7:0] tx_cks_q;
  logic tx_done_irq_q;
  logic rx_done_irq_q;
  logic irq_q;
  logic start;
  logic tx_done;
  logic hdr_stop;
  logic lin;
  logic cks_auto;
  logic rx_active;
  logic rx_end;
  logic rx_done;
  logic cks_err;
  logic hdr_seen;
  logic [7:0] tx_sum;
  logic [7:0] rx_sum;
  logic wr_feat;
  logic wr_en;
  logic wr_sts;
  logic wr_irq_en;
  logic wr_tx_req;

  assign wr_feat = wr_i && (addr_i == `LMA_OFS_FEATURE);
  assign wr_en = wr_i && (addr_i == `LMA_OFS_ENABLE);
  assign wr_sts = wr_i && (addr_i == `LMA_OFS_STATUS);
  assign wr_irq_en = wr_i && (addr_i == `LMA_OFS_IRQ_EN);
  assign wr_tx_req = wr_i && (addr_i == `LMA_OFS_TX_REQ);

  assign mode = lma_pkg::lma_mode_e'(feat_q[`LMA_BIT_MODE_HI:`LMA_BIT_MODE_LO]);
  // upper mode bit selects the lin master functions
  assign lin = feat_q[`LMA_BIT_MODE_HI];
  assign cks_auto = feat_q[`LMA_BIT_CKS_AUTO] && lin;
  assign rx_active = en_q && lin;
  assign rx_end = rx_active && rx_byte_valid_i && rx_byte_last_i;
  assign rx_done = rx_end;
  assign cks_err = rx_end && cks_auto && (rx_byte_i != ~rx_sum);
  assign hdr_seen = en_q && (st_q == lma_pkg::LMA_FS_SEND) && hdr_err_i;
  // only the stopping lin variant abandons the frame on a header error
  assign hdr_stop = hdr_seen && (mode == lma_pkg::LMA_MD_LIN_STOP);

  // feature bits are frozen while the unit runs, so a live frame never sees them move
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      feat_q <= `LMA_FEATURE_RST;
    end else if (wr_feat && !en_q) begin
      feat_q <= wdata_i[`LMA_FEATURE_W-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      en_q <= 1'b0;
      sched_q <= 1'b0;
    end else begin
      en_q <= wr_en ? wdata_i[`LMA_BIT_UNIT_EN] : en_q;
      sched_q <= feat_q[`LMA_BIT_SCHED] && (wr_en ? wdata_i[`LMA_BIT_UNIT_EN] : en_q);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_en_q <= `LMA_STS_RST;
    end else if (wr_irq_en) begin
      irq_en_q <= wdata_i[`LMA_STS_W-1:0];
    end
  end

  // software sets the request, the launch clears it; a set in the launch cycle wins
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_req_q <= 1'b0;
    end else if (!en_q) begin
      tx_req_q <= 1'b0;
    end else if (wr_tx_req && wdata_i[`LMA_BIT_TX_REQ]) begin
      tx_req_q <= 1'b1;
    end else if (start) begin
      tx_req_q <= 1'b0;
    end
  end

  always_comb begin
    st_d = st_q;
    start = 1'b0;
    tx_done = 1'b0;
    if (!en_q) begin
      st_d = lma_pkg::LMA_FS_IDLE;
    end else begin
      case (st_q)
        lma_pkg::LMA_FS_IDLE: begin
          if (lin && tx_req_q) begin
            if (feat_q[`LMA_BIT_AUTO_FRAME]) begin
              st_d = lma_pkg::LMA_FS_WAIT_IFS;
            end else begin
              start = 1'b1;
              st_d = lma_pkg::LMA_FS_SEND;
            end
          end
        end
        lma_pkg::LMA_FS_WAIT_IFS: begin
          if (ifs_elapsed_i) begin
            start = 1'b1;
            st_d = lma_pkg::LMA_FS_SEND;
          end
        end
        lma_pkg::LMA_FS_SEND: begin
          if (hdr_stop) begin
            st_d = lma_pkg::LMA_FS_IDLE;
          end else if (tx_byte_valid_i && tx_byte_last_i) begin
            if (cks_auto) begin
              st_d = lma_pkg::LMA_FS_CKS;
            end else begin
              tx_done = 1'b1;
              st_d = lma_pkg::LMA_FS_IDLE;
            end
          end
        end
        lma_pkg::LMA_FS_CKS: begin
          tx_done = 1'b1;
          st_d = lma_pkg::LMA_FS_IDLE;
        end
        default: begin
          st_d = lma_pkg::LMA_FS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= lma_pkg::LMA_FS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  lma_cks u_tx_cks (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(start || !en_q),
    .add_i((st_q == lma_pkg::LMA_FS_SEND) && tx_byte_valid_i),
    .byte_i(tx_byte_i),
    .sum_o(tx_sum)
  );

  lma_cks u_rx_cks (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(rx_end || !en_q),
    .add_i(rx_active && rx_byte_valid_i && !rx_byte_last_i),
    .byte_i(rx_byte_i),
    .sum_o(rx_sum)
  );

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      frame_start_q <= 1'b0;
      tx_cks_valid_q <= 1'b0;
      tx_cks_q <= 8'h00;
    end else begin
      frame_start_q <= start;
      tx_cks_valid_q <= en_q && (st_q == lma_pkg::LMA_FS_CKS);
      tx_cks_q <= (st_q == lma_pkg::LMA_FS_CKS) ? ~tx_sum : 8'h00;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_done_irq_q <= 1'b0;
      rx_done_irq_q <= 1'b0;
    end else begin
      tx_done_irq_q <= tx_done && !feat_q[`LMA_BIT_TX_MASK];
      rx_done_irq_q <= rx_done && !feat_q[`LMA_BIT_RX_MASK];
    end
  end

  always_comb begin
    sts_set = '0;
    sts_set[`LMA_STS_TX_DONE] = tx_done;
    sts_set[`LMA_STS_RX_DONE] = rx_done;
    sts_set[`LMA_STS_CKS_ERR] = cks_err;
    sts_set[`LMA_STS_HDR_ERR] = hdr_seen;
    sts_clr = wr_sts ? wdata_i[`LMA_STS_W-1:0] : `LMA_STS_RST;
    // a new event beats a clear written in the same cycle
    sts_d = en_q ? ((sts_q & ~sts_clr) | sts_set) : `LMA_STS_RST;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sts_q <= `LMA_STS_RST;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      irq_q <= |(sts_d & irq_en_q);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `LMA_OFS_FEATURE: rdata_q <= {9'h000, feat_q};
        `LMA_OFS_ENABLE: rdata_q <= {en_q, 15'h0000};
        `LMA_OFS_STATUS: rdata_q <= {12'h000, sts_q};
        `LMA_OFS_IRQ_EN: rdata_q <= {12'h000, irq_en_q};
        `LMA_OFS_TX_REQ: rdata_q <= {15'h0000, tx_req_q};
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign rdata_o = rdata_q;
  assign unit_clk_en_o = en_q;
  assign mode_select_o = feat_q[`LMA_BIT_MODE_HI:`LMA_BIT_MODE_LO];
  assign scheduler_en_o = sched_q;
  assign checksum_auto_en_o = feat_q[`LMA_BIT_CKS_AUTO];
  assign frame_start_o = frame_start_q;
  assign tx_cks_valid_o = tx_cks_valid_q;
  assign tx_cks_o = tx_cks_q;
  assign tx_done_irq_o = tx_done_irq_q;
  assign rx_done_irq_o = rx_done_irq_q;
  assign irq_o = irq_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence last_byte_auto_s;
    en_q && (st_q == lma_pkg::LMA_FS_SEND) && !hdr_stop && tx_byte_valid_i && tx_byte_last_i
      && cks_auto;
  endsequence

  sequence manual_launch_s;
    en_q && lin && tx_req_q && (st_q == lma_pkg::LMA_FS_IDLE) && !feat_q[`LMA_BIT_AUTO_FRAME];
  endsequence

  sequence auto_wait_s;
    en_q && (st_q == lma_pkg::LMA_FS_WAIT_IFS);
  endsequence

  cks_insert_a: assert property (last_byte_auto_s ##1 1'b1 |=> tx_cks_valid_o &&
    (tx_done_irq_o == !feat_q[`LMA_BIT_TX_MASK]))
    else $error("auto checksum not inserted after last byte");

  cks_off_a: assert property (tx_cks_valid_o |-> $past(feat_q[`LMA_BIT_CKS_AUTO], 2))
    else $error("checksum inserted while auto checksum off");

  rx_cks_a: assert property (rx_end && cks_auto && (rx_byte_i != ~rx_sum) |=>
    sts_q[`LMA_STS_CKS_ERR])
    else $error("bad received checksum not flagged");

  rx_cks_ok_a: assert property (rx_end && !cks_auto && !wr_sts &&
    !sts_q[`LMA_STS_CKS_ERR] |=> !sts_q[`LMA_STS_CKS_ERR])
    else $error("checksum error flagged with auto checksum off");

  sched_follow_a: assert property (wr_en && wdata_i[`LMA_BIT_UNIT_EN] &&
    feat_q[`LMA_BIT_SCHED] |=> scheduler_en_o)
    else $error("scheduler not enabled with unit");

  manual_start_a: assert property (manual_launch_s |=> frame_start_o)
    else $error("manual frame start missing");

  auto_hold_a: assert property (auto_wait_s ##0 !ifs_elapsed_i |=> !frame_start_o ##0
    (st_q != lma_pkg::LMA_FS_SEND))
    else $error("frame started before interframe space");

  auto_start_a: assert property (auto_wait_s ##0 ifs_elapsed_i |=>
    (st_q == lma_pkg::LMA_FS_SEND) ##0 frame_start_o)
    else $error("frame not started after interframe space");

  tx_mask_a: assert property (tx_done_irq_o |-> !$past(feat_q[`LMA_BIT_TX_MASK]))
    else $error("masked tx done interrupt raised");

  rx_mask_a: assert property (rx_done && !feat_q[`LMA_BIT_RX_MASK] |=> rx_done_irq_o)
    else $error("unmasked rx done interrupt missing");

  rx_masked_a: assert property (rx_done_irq_o |-> !$past(feat_q[`LMA_BIT_RX_MASK]))
    else $error("masked rx done interrupt raised");

  unit_clk_a: assert property (wr_en |=> unit_clk_en_o == $past(wdata_i[`LMA_BIT_UNIT_EN]))
    else $error("unit clock enable does not follow enable bit");

  halt_reset_a: assert property (!en_q |=> (st_q == lma_pkg::LMA_FS_IDLE) &&
    (sts_q == 4'h0) && !tx_req_q ##1 !frame_start_o)
    else $error("disabled unit not reset");

  mode_lin_a: assert property (frame_start_o |-> $past(lin, 2))
    else $error("frame started in uart mode");

  hdr_stop_a: assert property (hdr_seen && (mode == lma_pkg::LMA_MD_LIN_STOP) |=>
    (st_q == lma_pkg::LMA_FS_IDLE) && !tx_cks_valid_o)
    else $error("frame not stopped on header error");

  unmapped_rd_a: assert property (rd_i && !(addr_i inside {`LMA_OFS_FEATURE,
    `LMA_OFS_ENABLE, `LMA_OFS_STATUS, `LMA_OFS_IRQ_EN, `LMA_OFS_TX_REQ}) |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");

  feat_rd_a: assert property (rd_i && addr_i == `LMA_OFS_FEATURE |=>
    rdata_o[15:7] == 9'h000)
    else $error("unimplemented feature bits read nonzero");
endmodule : lma_ctrl

/* File: testbench/lma_far_model.sv */
// far side model: uart handing two frame bytes over after each launch
`timescale 1ns/1ps
module lma_far_model (
  input wire logic clk_i,       // clock
  input wire logic reset_i,     // async reset, active high
  input wire logic start_i,     // frame launched
  input wire logic [3:0] gap_i, // idle cycles before each byte
  output logic valid_o,         // byte handed over
  output logic [7:0] byte_o,    // byte value
  output logic last_o           // last data byte
);
  logic [1:0] idx_q;
  logic [3:0] wait_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      idx_q <= 2'h0;
      wait_q <= 4'h0;
      valid_o <= 1'b0;
      byte_o <= 8'h00;
      last_o <= 1'b0;
    end else if (start_i) begin
      idx_q <= 2'h1;
      wait_q <= gap_i;
      valid_o <= 1'b0;
      byte_o <= ~byte_o;
      last_o <= 1'b0;
    end else if (idx_q != 2'h0 && wait_q == 4'h0) begin
      valid_o <= 1'b1;
      byte_o <= (idx_q == 2'h1) ? 8'h10 : 8'h20;
      last_o <= (idx_q == 2'h2);
      idx_q <= (idx_q == 2'h2) ? 2'h0 : 2'h2;
      wait_q <= gap_i;
    end else begin
      // line not held between bytes: show a changing value, not the old one
      wait_q <= (wait_q != 4'h0) ? wait_q - 4'h1 : 4'h0;
      valid_o <= 1'b0;
      byte_o <= ~byte_o;
      last_o <= 1'b0;
    end
  end
endmodule : lma_far_model

/* File: testbench/tb_lin_master_assist_control.sv */
// self-checking bench for the lin master assist control block
`timescale 1ns/1ps
`include "lma_defs.svh"
module tb_lin_master_assist_control;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ifs_i = 1'b0;
  logic rxv_i = 1'b0;
  logic [7:0] rxb_i = 8'h00;
  logic rxl_i = 1'b0;
  logic hdr_i = 1'b0;
  logic [3:0] gap = 4'h0;
  logic [15:0] rdata;
  logic txv, txl, clk_en, sch, cks_en, fs, ckv, tdi, rdi, irq;
  logic [7:0] txb, cks, last_cks;
  logic [1:0] mode;
  int err_count = 0;
  int n_tests = 0;
  int n_fs = 0;
  int n_ckv = 0;
  int n_tdi = 0;
  int n_rdi = 0;
  logic [7:0] offs [6] = '{8'h80, 8'h84, 8'ha0, 8'ha4, 8'hd8, 8'h90};
  always #5 clk_i = ~clk_i;
  lma_ctrl DUT (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .ifs_elapsed_i(ifs_i),
    .tx_byte_valid_i(txv), .tx_byte_i(txb), .tx_byte_last_i(txl),
    .rx_byte_valid_i(rxv_i), .rx_byte_i(rxb_i), .rx_byte_last_i(rxl_i),
    .hdr_err_i(hdr_i), .unit_clk_en_o(clk_en), .mode_select_o(mode),
    .scheduler_en_o(sch), .checksum_auto_en_o(cks_en), .frame_start_o(fs),
    .tx_cks_valid_o(ckv), .tx_cks_o(cks), .tx_done_irq_o(tdi),
    .rx_done_irq_o(rdi), .irq_o(irq));
  lma_far_model far (.clk_i(clk_i), .reset_i(reset_i), .start_i(fs), .gap_i(gap),
    .valid_o(txv), .byte_o(txb), .last_o(txl));
  // pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge clk_i) begin
    if (fs === 1'b1) n_fs++;
    if (tdi === 1'b1) n_tdi++;
    if (rdi === 1'b1) n_rdi++;
    if (ckv === 1'b1) begin
      n_ckv++;
      last_cks = cks;
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  `define CHK(g, e) cmp(16'(g), 16'(e))
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    cmp(rdata, e);
  endtask : rdc
  task automatic rxs(input logic [7:0] b, input logic l);
    @(posedge clk_i);
    rxv_i <= 1'b1;
    rxb_i <= b;
    rxl_i <= l;
    @(posedge clk_i);
    rxv_i <= 1'b0;
    rxb_i <= ~b;
    rxl_i <= 1'b0;
  endtask : rxs
  task automatic pulse_ifs;
    @(posedge clk_i);
    ifs_i <= 1'b1;
    @(posedge clk_i);
    ifs_i <= 1'b0;
  endtask : pulse_ifs
  task automatic setup(input logic [15:0] f);
    wr(`LMA_OFS_ENABLE, 16'h0000);
    wr(`LMA_OFS_FEATURE, f);
    wr(`LMA_OFS_ENABLE, 16'h8000);
  endtask : setup
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (offs[i]) rdc(offs[i], 16'h0000);
    wr(`LMA_OFS_FEATURE, 16'hffff);
    rdc(`LMA_OFS_FEATURE, 16'h007f);
    `CHK(sch, 0);
    wr(`LMA_OFS_ENABLE, 16'hffff);
    rdc(`LMA_OFS_ENABLE, 16'h8000);
    `CHK(clk_en, 1);
    `CHK(sch, 1);
    wr(`LMA_OFS_FEATURE, 16'h0000);
    rdc(`LMA_OFS_FEATURE, 16'h007f);
    wr(`LMA_OFS_ENABLE, 16'h0000);
    `CHK(clk_en, 0);
    for (int m = 0; m < 4; m++) begin
      wr(`LMA_OFS_FEATURE, 16'(m) << 5);
      `CHK(mode, m);
    end
    wr(`LMA_OFS_FEATURE, 16'h0050);
    `CHK(cks_en, 1);
    wr(`LMA_OFS_FEATURE, 16'h0040);
    `CHK(cks_en, 0);
    $display("test registers done");
    wr(`LMA_OFS_IRQ_EN, 16'h0003);
    setup(16'h0050);
    wr(`LMA_OFS_TX_REQ, 16'h0001);
    @(posedge clk_i);
    #1;
    `CHK(fs, 1);
    cyc(8);
    `CHK(n_ckv, 1);
    `CHK(last_cks, 8'hcf);
    `CHK(n_tdi, 1);
    `CHK(irq, 1);
    rdc(`LMA_OFS_STATUS, 16'h0001);
    rdc(`LMA_OFS_TX_REQ, 16'h0000);
    wr(`LMA_OFS_STATUS, 16'h0001);
    rdc(`LMA_OFS_STATUS, 16'h0000);
    `CHK(irq, 0);
    rxs(8'h10, 1'b0);
    rxs(8'h20, 1'b0);
    rxs(8'hcf, 1'b1);
    cyc(1);
    `CHK(n_rdi, 1);
    rdc(`LMA_OFS_STATUS, 16'h0002);
    rxs(8'h10, 1'b0);
    rxs(8'h00, 1'b1);
    cyc(1);
    rdc(`LMA_OFS_STATUS, 16'h0006);
    $display("test manual frame done");
    setup(16'h004c);
    wr(`LMA_OFS_TX_REQ, 16'h0001);
    cyc(4);
    `CHK(n_fs, 1);
    pulse_ifs();
    #1;
    `CHK(fs, 1);
    cyc(8);
    `CHK(n_ckv, 1);
    `CHK(n_tdi, 2);
    $display("test auto frame done");
    setup(16'h0043);
    wr(`LMA_OFS_TX_REQ, 16'h0001);
    cyc(2);
    hdr_i <= 1'b1;
    cyc(1);
    hdr_i <= 1'b0;
    cyc(7);
    `CHK(n_tdi, 2);
    rdc(`LMA_OFS_STATUS, 16'h0009);
    rxs(8'h01, 1'b0);
    rxs(8'hfe, 1'b1);
    cyc(1);
    `CHK(n_rdi, 2);
    rdc(`LMA_OFS_STATUS, 16'h000b);
    $display("test masks done");
    setup(16'h0060);
    gap <= 4'h8;
    wr(`LMA_OFS_TX_REQ, 16'h0001);
    cyc(2);
    hdr_i <= 1'b1;
    cyc(1);
    hdr_i <= 1'b0;
    rdc(`LMA_OFS_STATUS, 16'h0008);
    cyc(30);
    `CHK(n_tdi, 2);
    wr(`LMA_OFS_TX_REQ, 16'h0001);
    cyc(4);
    wr(`LMA_OFS_ENABLE, 16'h0000);
    rdc(`LMA_OFS_STATUS, 16'h0000);
    rdc(`LMA_OFS_TX_REQ, 16'h0000);
    `CHK(clk_en, 0);
    cyc(30);
    `CHK(n_tdi, 2);
    $display("test abort done");
    setup(16'h0000);
    wr(`LMA_OFS_TX_REQ, 16'h0001);
    pulse_ifs();
    cyc(5);
    `CHK(n_fs, 5);
    rdc(`LMA_OFS_TX_REQ, 16'h0001);
    $display("test uart mode done");
    give_verdict();
  end
endmodule : tb_lin_master_assist_control
